/* File: hdl/spfsc_pkg.sv */
package spfsc_pkg;

  // command opcodes issued to the flash
  localparam logic [7:0] OP_RD_SR1  = 8'h05;
  localparam logic [7:0] OP_RD_SR2  = 8'h35;
  localparam logic [7:0] OP_RD_SR3  = 8'h15;
  localparam logic [7:0] OP_RD_SRX  = 8'h65;
  localparam logic [7:0] OP_WR_SR1  = 8'h01;
  localparam logic [7:0] OP_WR_SR2  = 8'h31;
  localparam logic [7:0] OP_WR_SR3  = 8'h11;
  localparam logic [7:0] OP_WR_SRX  = 8'h71;
  localparam logic [7:0] OP_RESUME  = 8'hAB;

  // frame layout figures
  localparam int          BYTE_BITS    = 8;
  localparam int          NUM_SR       = 5;
  localparam logic [7:0]  DUMMY_BYTE   = 8'h00;
  localparam int          SCK_HALF_DEF = 4;   // refclk cycles per sck half period
  localparam int          SCK_HALF_MIN = 4;   // covers the two-flop input delay

  // controller register offsets (byte addresses, 32-bit words)
  localparam logic [5:0]  OFF_CMD    = 6'h00;
  localparam logic [5:0]  OFF_ADDR   = 6'h04;
  localparam logic [5:0]  OFF_WDATA  = 6'h08;
  localparam logic [5:0]  OFF_RCOUNT = 6'h0C;
  localparam logic [5:0]  OFF_RBUF0  = 6'h10;
  localparam logic [5:0]  OFF_STATUS = 6'h24;

  // field positions
  localparam int          CMD_GO_BIT   = 8;
  localparam int          ST_BUSY_BIT  = 0;
  localparam int          ST_DONE_BIT  = 1;
  localparam int          ST_REJ_BIT   = 2;

  // reset values
  localparam logic [7:0]  ADDR_RST   = 8'h01;
  localparam logic [7:0]  WDATA_RST  = 8'h00;
  localparam logic [2:0]  RCOUNT_RST = 3'h1;

  typedef enum logic [4:0] {
    SPFSC_IDLE  = 5'b00001,
    SPFSC_LEAD  = 5'b00010,
    SPFSC_SHIFT = 5'b00100,
    SPFSC_TRAIL = 5'b01000,
    SPFSC_GAP   = 5'b10000
  } spfsc_state_t;

endpackage : spfsc_pkg

/* File: hdl/spfsc_sync.sv */
`timescale 1ns/1ps
// two-flop synchroniser for levels arriving from pins
module spfsc_sync #(
  parameter int W = 1
) (
  input  wire logic         REF_CLK,
  input  wire logic         RST,
  input  wire logic [W-1:0] D,
  output logic      [W-1:0] Q
);

  // a zero-width synchroniser would leave its output undriven
  if (W < 1) begin : g_bad_w
    $error("W must be at least one");
  end

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  // first stage feeds only the second stage
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= D;
      sync_reg <= meta_reg;
    end
  end

  assign Q = sync_reg;

endmodule : spfsc_sync

/* File: hdl/spfsc_host.sv */
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ps
// Notes on behaviour
// - the lane pattern is opcode-address-data; every command sent here is 1-0-1, 1-1-1 or 1-0-0.
// - opcode 05h is sent alone and one byte is then read back.
// - opcode 35h is sent alone and one byte is read back over eight clocks.
// - opcode 15h is sent alone and one byte is read back over eight clocks.
// - opcode 65h is followed by one address byte and one dummy byte, then as many bytes as the count asks for, one to five, are read.
// - register five is read through 65h too, the address byte choosing the register.
// - opcode 01h is followed directly by one data byte, with no address.
// - opcode 31h is followed directly by one data byte.
// - opcode 11h is followed directly by one data byte.
// - opcode 71h is followed by one address byte and then one data byte, no dummy.
// - register five is written through 71h too, the address byte choosing the register.
// - opcode ABh is sent alone to wake the flash from its deepest power-down.
// - each frame begins with chip select low and an eight-bit opcode, all bytes MSB first.
module spfsc_host
  import spfsc_pkg::*;
#(
  parameter int SCK_HALF = spfsc_pkg::SCK_HALF_DEF
) (
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  input  wire logic [5:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  output logic             BUSY,
  output logic             SPI_CS_N,
  output logic             SPI_SCK,
  output logic             SPI_MOSI,
  input  wire logic        SPI_MISO
);

  import spfsc_pkg::*;

  // refuse divider settings that leave no room for the input synchroniser
  if (SCK_HALF < SCK_HALF_MIN || SCK_HALF > 255) begin : g_bad_half
    $error("SCK_HALF out of range");
  end

  // the frame length and read-back offsets live in 7-bit counters, and the
  // byte index of the read buffer in three bits; longer frames would wrap
  if ((3 + NUM_SR) * BYTE_BITS > 127 || NUM_SR > 7) begin : g_bad_len
    $error("frame too long for the bit counters");
  end

  localparam logic [7:0] HALF_LAST = 8'(SCK_HALF - 1);

  // sequencer and shift path
  spfsc_state_t state_reg;
  logic [7:0]   hc_reg;          // half-period counter
  logic         phase_reg;       // 0 while sck low, 1 while sck high
  logic [6:0]   bit_reg;         // index of the bit on the wire
  logic [6:0]   total_reg;       // bits in this frame
  logic [6:0]   rxs_reg;         // first bit of the read-back phase
  logic [23:0]  tx_reg;          // outgoing bytes, msb on the wire
  logic [7:0]   rx_reg;
  logic [7:0]   rbuf_reg [NUM_SR];

  // pin and software-facing state
  logic         cs_n_reg;
  logic         sck_reg;
  logic [7:0]   op_reg;
  logic [7:0]   adr_reg;
  logic [7:0]   wd_reg;
  logic [2:0]   cnt_reg;
  logic         done_reg;
  logic         rej_reg;
  logic [31:0]  rdata_reg;
  logic         miso_s;

  // decode and read-back helpers
  logic         cmd_wr;
  logic         launch;
  logic         refuse;
  logic [6:0]   fmt;
  logic [2:0]   rd_bytes;
  logic         half_end;
  logic [7:0]   rx_next;
  logic [6:0]   rx_off;
  logic [2:0]   rb_idx;
  logic [3:0]   rd_word;

  // the read-back line is a pin: two flops before any logic sees it
  // their two cycles of delay are why a half period is at least four clocks
  spfsc_sync #(
    .W (1)
  ) u_miso_sync (
    .REF_CLK (REF_CLK),
    .RST     (RST),
    .D       (SPI_MISO),
    .Q       (miso_s)
  );

  // frame shape per opcode: {known, addr byte, dummy byte, write byte, read bytes}
  // a 65h frame reads back as many registers as the count asks for
  function automatic logic [6:0] cmd_format(input logic [7:0] op, input logic [2:0] cnt);
    logic [6:0] f;
    f = 7'h00;
    case (op)
      OP_RD_SR1: f = {1'b1, 1'b0, 1'b0, 1'b0, 3'h1};
      OP_RD_SR2: f = {1'b1, 1'b0, 1'b0, 1'b0, 3'h1};
      OP_RD_SR3: f = {1'b1, 1'b0, 1'b0, 1'b0, 3'h1};
      OP_RD_SRX: f = {1'b1, 1'b1, 1'b1, 1'b0, cnt};
      OP_WR_SR1: f = {1'b1, 1'b0, 1'b0, 1'b1, 3'h0};
      OP_WR_SR2: f = {1'b1, 1'b0, 1'b0, 1'b1, 3'h0};
      OP_WR_SR3: f = {1'b1, 1'b0, 1'b0, 1'b1, 3'h0};
      OP_WR_SRX: f = {1'b1, 1'b1, 1'b0, 1'b1, 3'h0};
      OP_RESUME: f = {1'b1, 1'b0, 1'b0, 1'b0, 3'h0};
      default:   f = 7'h00;
    endcase
    return f;
  endfunction : cmd_format

  // command decode; unknown opcodes never reach the pins, so the flash
  // never has to sit out a frame it cannot parse
  // a go bit of zero makes this a plain write that starts nothing
  assign cmd_wr   = WR && (ADDR == OFF_CMD) && WDATA[CMD_GO_BIT];
  assign fmt      = cmd_format(WDATA[7:0], cnt_reg);
  assign launch   = cmd_wr && (state_reg == SPFSC_IDLE) && fmt[6];
  assign refuse   = cmd_wr && !launch;
  assign rd_bytes = fmt[2:0];
  assign half_end = (hc_reg == HALF_LAST);

  // read-back bookkeeping
  assign rx_next  = {rx_reg[6:0], miso_s};
  assign rx_off   = bit_reg - rxs_reg;
  assign rb_idx   = rx_off[5:3];

  // software-facing settings
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      op_reg  <= 8'h00;
      adr_reg <= ADDR_RST;
      wd_reg  <= WDATA_RST;
      cnt_reg <= RCOUNT_RST;
    end else if (WR && state_reg == SPFSC_IDLE) begin
      // settings are frozen while a frame runs, so the frame stays coherent
      case (ADDR)
        OFF_ADDR:   adr_reg <= WDATA[7:0];
        OFF_WDATA:  wd_reg  <= WDATA[7:0];
        OFF_RCOUNT: begin
          // one to five registers per 65h frame; out-of-range counts clamp
          // clamping instead of refusing keeps every byte inside the buffer
          if (WDATA[2:0] == 3'h0) begin
            cnt_reg <= 3'h1;
          end else if (WDATA[2:0] > 3'(NUM_SR)) begin
            cnt_reg <= 3'(NUM_SR);
          end else begin
            cnt_reg <= WDATA[2:0];
          end
        end
        OFF_CMD: begin
          if (launch) begin
            op_reg <= WDATA[7:0];
          end
        end
        default: ;
      endcase
    end
  end

  // frame sequencer: chip select, clock phases and bit position
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      state_reg <= SPFSC_IDLE;
      hc_reg    <= 8'h00;
      phase_reg <= 1'b0;
      bit_reg   <= 7'h00;
      cs_n_reg  <= 1'b1;
      sck_reg   <= 1'b0;
    end else begin
      case (state_reg)
        SPFSC_IDLE: begin
          hc_reg    <= 8'h00;
          phase_reg <= 1'b0;
          bit_reg   <= 7'h00;
          sck_reg   <= 1'b0;
          if (launch) begin
            cs_n_reg  <= 1'b0;
            state_reg <= SPFSC_LEAD;
          end
        end
        SPFSC_LEAD: begin
          // one half period of setup before the first rising edge
          // the low half of bit 0 follows, so sck first rises 2H after select
          hc_reg <= half_end ? 8'h00 : hc_reg + 8'h01;
          if (half_end) begin
            state_reg <= SPFSC_SHIFT;
          end
        end
        SPFSC_SHIFT: begin
          hc_reg <= half_end ? 8'h00 : hc_reg + 8'h01;
          if (half_end) begin
            if (!phase_reg) begin
              sck_reg   <= 1'b1;         // rising edge: flash samples mosi
              phase_reg <= 1'b1;
            end else begin
              sck_reg   <= 1'b0;         // falling edge: next bit goes out
              phase_reg <= 1'b0;
              // the last fall ends the frame and leaves the bit index in range
              if (bit_reg == total_reg - 7'h01) begin
                state_reg <= SPFSC_TRAIL;
              end else begin
                bit_reg <= bit_reg + 7'h01;
              end
            end
          end
        end
        SPFSC_TRAIL: begin
          // frames always run to the last bit; no partial frame is ever cut
          hc_reg <= half_end ? 8'h00 : hc_reg + 8'h01;
          if (half_end) begin
            cs_n_reg  <= 1'b1;
            state_reg <= SPFSC_GAP;
          end
        end
        SPFSC_GAP: begin
          // deselect time so the flash sees a clean frame boundary
          hc_reg <= half_end ? 8'h00 : hc_reg + 8'h01;
          if (half_end) begin
            state_reg <= SPFSC_IDLE;
          end
        end
        default: begin
          state_reg <= SPFSC_IDLE;
          cs_n_reg  <= 1'b1;
          sck_reg   <= 1'b0;
        end
      endcase
    end
  end

  // frame length and byte order, fixed at launch
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      total_reg <= 7'h00;
      rxs_reg   <= 7'h00;
      tx_reg    <= 24'h000000;
    end else if (launch) begin
      total_reg <= 7'((7'h01 + 7'(fmt[5]) + 7'(fmt[4]) + 7'(fmt[3]) + 7'(rd_bytes))
                      * 7'(BYTE_BITS));
      // write frames read nothing back, so their start lies past the last bit
      rxs_reg   <= 7'((7'h01 + 7'(fmt[5]) + 7'(fmt[4]) + 7'(fmt[3]))
                      * 7'(BYTE_BITS));
      // opcode first, then address or data, then dummy or data
      if (fmt[5] && fmt[3]) begin
        tx_reg <= {WDATA[7:0], adr_reg, wd_reg};
      end else if (fmt[5]) begin
        tx_reg <= {WDATA[7:0], adr_reg, DUMMY_BYTE};
      end else if (fmt[3]) begin
        tx_reg <= {WDATA[7:0], wd_reg, DUMMY_BYTE};
      end else begin
        tx_reg <= {WDATA[7:0], 16'h0000};
      end
    end else if (state_reg == SPFSC_SHIFT && half_end && phase_reg) begin
      tx_reg <= {tx_reg[22:0], 1'b0};
    end
  end

  // read-back: sample late in the high half, past the synchroniser delay,
  // and only once the flash is in its data phase
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      rx_reg <= 8'h00;
      for (int i = 0; i < NUM_SR; i++) begin
        rbuf_reg[i] <= 8'h00;
      end
    end else if (state_reg == SPFSC_SHIFT && half_end && phase_reg
                 && bit_reg >= rxs_reg) begin
      rx_reg <= rx_next;
      // a byte cut short never reaches the buffer
      if (rx_off[2:0] == 3'h7) begin
        rbuf_reg[rb_idx] <= rx_next;
      end
    end
  end

  // done is set at frame end and cleared by writing one; set wins
  // software polls done rather than busy, so a short frame is never missed
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      done_reg <= 1'b0;
    end else if (state_reg == SPFSC_GAP && half_end) begin
      done_reg <= 1'b1;
    end else if (WR && ADDR == OFF_STATUS && WDATA[ST_DONE_BIT]) begin
      done_reg <= 1'b0;
    end
  end

  // reject flags a go while busy or with an opcode this block cannot frame
  // a refused go leaves every setting and the pins as they were
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      rej_reg <= 1'b0;
    end else if (refuse) begin
      rej_reg <= 1'b1;
    end else if (WR && ADDR == OFF_STATUS && WDATA[ST_REJ_BIT]) begin
      rej_reg <= 1'b0;
    end
  end

  // register read port: data stand the cycle after the strobe
  assign rd_word = ADDR[5:2] - OFF_RBUF0[5:2];
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      rdata_reg <= 32'h00000000;
    end else if (RD) begin
      case (ADDR)
        OFF_CMD:    rdata_reg <= {24'h000000, op_reg};
        OFF_ADDR:   rdata_reg <= {24'h000000, adr_reg};
        OFF_WDATA:  rdata_reg <= {24'h000000, wd_reg};
        OFF_RCOUNT: rdata_reg <= {29'h00000000, cnt_reg};
        OFF_STATUS: rdata_reg <= {29'h00000000, rej_reg, done_reg,
                                  state_reg != SPFSC_IDLE};
        default: begin
          // read buffer words; anything else unmapped reads zero
          if (ADDR[1:0] == 2'h0 && ADDR >= OFF_RBUF0
              && rd_word < 4'(NUM_SR)) begin
            rdata_reg <= {24'h000000, rbuf_reg[rd_word[2:0]]};
          end else begin
            rdata_reg <= 32'h00000000;
          end
        end
      endcase
    end else begin
      // idle cycles read zero, so a stale word is never taken for data
      rdata_reg <= 32'h00000000;
    end
  end

  // select and clock come straight from flops; mosi is tx_reg[23] forced low while idle
  // mosi parks low between frames; a deselected flash ignores it
  assign SPI_CS_N = cs_n_reg;
  assign SPI_SCK  = sck_reg;
  assign SPI_MOSI = (state_reg == SPFSC_IDLE) ? 1'b0 : tx_reg[23];
  assign RDATA    = rdata_reg;
  assign BUSY     = (state_reg != SPFSC_IDLE);

endmodule : spfsc_host

/* File: test/spfsc_host_checker.sv */
`timescale 1ns/1ps
module spfsc_host_checker
  import spfsc_pkg::*;
#(
  parameter int SCK_HALF = 4
) (
  input wire logic        REF_CLK,
  input wire logic        RST,
  input wire logic [5:0]  ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  input wire logic        BUSY,
  input wire logic        SPI_CS_N,
  input wire logic        SPI_SCK,
  input wire logic        SPI_MOSI,
  input wire logic        SPI_MISO
);
  // select falls, one half period of lead, then the low half of bit 0
  localparam int FIRST_RISE = 2 * SCK_HALF;
  logic [7:0] rise_cnt_reg;
  logic       sck_q_reg;
  // sck rises per frame, judged when select lifts
  always_ff @(posedge REF_CLK) begin
    sck_q_reg <= RST ? 1'b0 : SPI_SCK;
    if (RST || SPI_CS_N) begin
      rise_cnt_reg <= 8'h00;
    end else if (SPI_SCK && !sck_q_reg) begin
      rise_cnt_reg <= rise_cnt_reg + 8'h01;
    end
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  a_idle_deselect: assert property (!BUSY |-> SPI_CS_N)
    else $error("select low while idle");
  a_sck_parked: assert property (SPI_CS_N |-> !SPI_SCK)
    else $error("clock moves outside a frame");
  a_first_edge: assert property ($fell(SPI_CS_N) |-> !SPI_SCK ##FIRST_RISE SPI_SCK)
    else $error("first clock rise misplaced");
  a_mosi_steady: assert property (SPI_SCK |-> $stable(SPI_MOSI))
    else $error("data changed while clock high");
  a_half_period: assert property ($rose(SPI_SCK) |-> ##SCK_HALF $fell(SPI_SCK))
    else $error("clock high time wrong");
  a_whole_bytes: assert property ($rose(SPI_CS_N) |->
    rise_cnt_reg[2:0] == 3'h0 && rise_cnt_reg >= 8'h08)
    else $error("frame not whole bytes");
  a_done_after_cs: assert property ($rose(SPI_CS_N) |-> BUSY ##SCK_HALF !BUSY)
    else $error("busy not ended after deselect");
  a_refuse_unknown: assert property (WR && ADDR == OFF_CMD && WDATA[8:0] == 9'h1C3 && !BUSY
    |=> !BUSY && SPI_CS_N)
    else $error("unknown opcode was sent");
endmodule : spfsc_host_checker

bind spfsc_host spfsc_host_checker #(.SCK_HALF(SCK_HALF)) u_spfsc_host_checker (
  .REF_CLK(REF_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .BUSY(BUSY), .SPI_CS_N(SPI_CS_N), .SPI_SCK(SPI_SCK),
  .SPI_MOSI(SPI_MOSI), .SPI_MISO(SPI_MISO));

/* File: test/spfsc_flash_model.sv */
`timescale 1ns/1ps
// behavioural flash: five status registers, spi mode 0
module spfsc_flash_model (
  input  wire logic cs_n,
  input  wire logic sck,
  input  wire logic si,
  output logic      so
);
  logic [7:0] sr [1:5];
  logic [7:0] sh, op, adr;
  int         n, base, idx;
  logic       last;
  // contents read zero until the bench writes them
  initial begin
    sr = '{default: 8'h00};
    n = 0;
    op = 8'h00;
    last = 1'b0;
    so = 1'b1;
  end
  // deselect ends any command, whole or cut short, and drives the output to the inverse of the last bit
  always @(posedge cs_n) begin
    n = 0;
    op = 8'h00;
    so = ~last;
  end
  // msb first on rising clock; no sleep state here, so resume needs nothing
  always @(posedge sck) if (!cs_n) begin
    sh = {sh[6:0], si};
    n++;
    if (n == 8) op = sh;
    if (n == 16) adr = sh;
    if (n == 16 && op == 8'h01) sr[1] = sh;
    if (n == 16 && op == 8'h31) sr[2] = sh;
    if (n == 16 && op == 8'h11) sr[3] = sh;
    if (n == 24 && op == 8'h71 && adr inside {[1:5]}) sr[adr[2:0]] = sh;
  end
  // drive only in the data phase; elsewhere the inverse of the last bit, never a stale copy
  always @(negedge sck) if (!cs_n) begin
    base = (op == 8'h65) ? 24 : 8;
    idx = (op == 8'h05) ? 1 : (op == 8'h35) ? 2 : (op == 8'h15) ? 3 : 0;
    if (op == 8'h65) idx = (adr == 8'h01) ? 1 + (n - base) / 8 : int'(adr);
    if (idx >= 1 && idx <= 5 && n >= base) so = sr[idx][7 - (n - base) % 8];
    else so = ~last;
    last = so;
  end
endmodule : spfsc_flash_model

/* File: test/spfsc_host_test.sv */
`timescale 1ns/1ps
module spfsc_host_test;
  import spfsc_pkg::*;
  logic        REF_CLK, RST, WR, RD, BUSY, SPI_CS_N, SPI_SCK, SPI_MOSI, SPI_MISO;
  logic [5:0]  ADDR;
  logic [31:0] WDATA, RDATA, seed, got;
  logic [7:0]  sr [1:5];
  logic        bits [$];
  int          n_mismatch, compares;

  spfsc_host u_spfsc_host (.REF_CLK(REF_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .BUSY(BUSY), .SPI_CS_N(SPI_CS_N),
    .SPI_SCK(SPI_SCK), .SPI_MOSI(SPI_MOSI), .SPI_MISO(SPI_MISO));
  spfsc_flash_model u_spfsc_flash_model (.cs_n(SPI_CS_N), .sck(SPI_SCK),
    .si(SPI_MOSI), .so(SPI_MISO));

  initial begin
    REF_CLK = 1'b0;
    forever #4 REF_CLK = ~REF_CLK;
  end
  // every bit clocked out while selected
  always @(posedge SPI_SCK) if (!SPI_CS_N) bits.push_back(SPI_MOSI);

  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : xs
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge REF_CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge REF_CLK);
    WR <= 1'b0;
  endtask : wr
  // read data is only valid in the cycle after the strobe
  task automatic rd(input logic [5:0] a);
    @(posedge REF_CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge REF_CLK);
    RD <= 1'b0;
    #1 got = RDATA;
  endtask : rd
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop
  // bounded wait for the frame to finish; busy is looked at 1 ns past the edge
  task automatic wait_idle();
    int i;
    for (i = 0; i < 2000; i++) begin
      @(posedge REF_CLK);
      #1;
      if (BUSY === 1'b0) break;
    end
    if (i == 2000) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask : wait_idle
  // one command: launch, wait, check the wire bytes, the read-back and the status
  task automatic frame(input logic [7:0] op, input int a, input logic [7:0] d, input int rc);
    logic [7:0] tx [$];
    int nr, i, idx;
    tx = {op};
    nr = (op == OP_RD_SRX) ? rc : (op inside {OP_RD_SR1, OP_RD_SR2, OP_RD_SR3}) ? 1 : 0;
    if (op inside {OP_RD_SRX, OP_WR_SRX}) tx.push_back(8'(a));
    if (op == OP_RD_SRX) tx.push_back(DUMMY_BYTE);
    if (op inside {OP_WR_SR1, OP_WR_SR2, OP_WR_SR3, OP_WR_SRX}) tx.push_back(d);
    wr(OFF_ADDR, a);
    wr(OFF_WDATA, {24'h0, d});
    wr(OFF_RCOUNT, rc);
    bits = {};
    wr(OFF_CMD, {23'h0, 1'b1, op});
    wait_idle();
    chk(32'(bits.size()), 32'(8 * (tx.size() + nr)));
    for (i = 0; i < tx.size(); i++) begin
      got = 0;
      for (int b = 0; b < 8; b++) got = {got[30:0], bits[8 * i + b]};
      chk(got, {24'h0, tx[i]});
    end
    case (op)
      OP_WR_SR1: sr[1] = d;
      OP_WR_SR2: sr[2] = d;
      OP_WR_SR3: sr[3] = d;
      OP_WR_SRX: sr[a] = d;
      default: ;
    endcase
    for (i = 0; i < nr; i++) begin
      idx = (op == OP_RD_SR1) ? 1 : (op == OP_RD_SR2) ? 2 : 3;
      if (op == OP_RD_SRX) idx = (a == 1) ? 1 + i : a;
      rd(6'(OFF_RBUF0 + 4 * i));
      chk(got, {24'h0, sr[idx]});
    end
    rd(OFF_CMD);
    chk(got, {24'h0, op});
    rd(OFF_STATUS);
    chk(got, 32'h2);
    wr(OFF_STATUS, 32'h2);
  endtask : frame

  initial begin
    RST = 1'b1;
    WR = 1'b0;
    RD = 1'b0;
    ADDR = 6'h00;
    WDATA = 32'h0;
    seed = 32'hDE5E;
    repeat (6) @(posedge REF_CLK);
    RST <= 1'b0;
    // reset values and an unmapped hole
    rd(OFF_ADDR);
    chk(got, 32'h1);
    // read data stand one cycle only, then fall back to zero
    @(posedge REF_CLK);
    #1;
    chk(RDATA, 32'h0);
    rd(OFF_RCOUNT);
    chk(got, 32'h1);
    rd(OFF_STATUS);
    chk(got, 32'h0);
    rd(6'h3C);
    chk(got, 32'h0);
    frame(OP_RESUME, 1, 8'h00, 1);
    frame(OP_WR_SR1, 1, xs(), 1);
    frame(OP_WR_SR2, 1, xs(), 1);
    frame(OP_WR_SR3, 1, xs(), 1);
    frame(OP_WR_SRX, 4, xs(), 1);
    frame(OP_WR_SRX, 5, xs(), 1);
    frame(OP_RD_SR1, 1, 8'h00, 1);
    frame(OP_RD_SR2, 1, 8'h00, 1);
    frame(OP_RD_SR3, 1, 8'h00, 1);
    frame(OP_RD_SRX, 4, 8'h00, 1);
    frame(OP_RD_SRX, 5, 8'h00, 1);
    frame(OP_RD_SRX, 1, 8'h00, 5);
    // a write frame must leave the read buffer alone
    frame(OP_WR_SR2, 1, xs(), 1);
    rd(OFF_RBUF0);
    chk(got, {24'h0, sr[1]});
    // an opcode the block does not know is refused, never framed
    wr(OFF_CMD, 32'h1C3);
    rd(OFF_STATUS);
    chk(got, 32'h4);
    wr(OFF_STATUS, 32'h4);
    rd(OFF_STATUS);
    chk(got, 32'h0);
    // a go while a frame runs is refused and leaves that frame alone
    wr(OFF_CMD, {23'h0, 1'b1, OP_RESUME});
    rd(OFF_STATUS);
    chk(got, 32'h1);
    wr(OFF_CMD, {23'h0, 1'b1, OP_RD_SR1});
    rd(OFF_STATUS);
    chk(got, 32'h5);
    wait_idle();
    rd(OFF_CMD);
    chk(got, {24'h0, OP_RESUME});
    wr(OFF_STATUS, 32'h6);
    rd(OFF_STATUS);
    chk(got, 32'h0);
    report_and_stop();
  end
endmodule : spfsc_host_test
